// File: hw/port3_rate_limit_control.v
`timescale 1ns/10ps
`include "rate_limit_regs.vh"

module port3_rate_limit_control (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [11:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // Ingress traffic
  input  wire        ingressByte,
  input  wire [1:0]  ingressPrio,
  output wire [3:0]  ingressDrop,
  // Egress traffic
  input  wire        egressByte,
  input  wire [1:0]  egressPrio,
  output wire [1:0]  egressHold,
  output wire        egressQueue,
  // Reduced-MII sampling
  output wire        rmiiSampleFalling,
  // Address table and queue mode control
  input  wire        flushDynDone,
  output wire        flushDynReq,
  output wire        flushStaticEn,
  output wire [2:0]  learnDisable,
  output wire        twoQueueMode
);

  reg  [15:0] ingLo_q;
  reg  [15:0] ingLo_d;
  reg  [15:0] ingHi_q;
  reg  [15:0] ingHi_d;
  reg  [15:0] egrLo_q;
  reg  [15:0] egrLo_d;
  reg  [15:0] egrHi_q;
  reg  [15:0] egrHi_d;
  reg  [15:0] global_q;
  reg  [15:0] global_d;
  reg  [15:0] queueLearn_q;
  reg  [15:0] queueLearn_d;
  reg         ack_q;
  reg  [31:0] rdData_q;
  reg  [31:0] rdData_d;
  reg         egrQueue_q;
  reg  [9:0]  window_q;
  wire        windowTick;
  wire        access;
  wire        wrEn;
  wire        rdEn;
  wire [9:0]  wordIdx;
  wire [15:0] wrWord;
  wire [27:0] rateCodes;
  wire [3:0]  ingConsume;
  wire [1:0]  egrConsume;
  wire [1:0]  egrLimitEn;
  wire        egrQueueNow;

  // Byte-lane merge of a 16-bit register
  function [15:0] lane_merge;
    input [15:0] oldVal;
    input [15:0] newVal;
    input [1:0]  sel;
    input [15:0] mask;
    reg   [15:0] merged;
    begin
      merged = oldVal;
      if (sel[0])
        merged[7:0] = newVal[7:0];
      if (sel[1])
        merged[15:8] = newVal[15:8];
      lane_merge = (merged & mask) | (oldVal & ~mask);
    end
  endfunction

  // Queue for an egress priority
  function queue_of;
    input [1:0] mapCode;
    input       twoQ;
    input [1:0] prio;
    begin
      if (!twoQ)
        queue_of = 1'b0;
      else if (mapCode == `MAP_SPLIT_A || mapCode == `MAP_SPLIT_B)
        queue_of = (prio != 2'h0);
      else
        queue_of = 1'b0;
    end
  endfunction

  assign access  = wb_cyc_i && wb_stb_i && !ack_q;
  assign wrEn    = access && wb_we_i;
  assign rdEn    = access && !wb_we_i;
  assign wordIdx = wb_adr_i[11:2];
  assign wrWord  = wb_dat_i[15:0];

  // Register writes
  always @*
  begin
    ingLo_d      = ingLo_q;
    ingHi_d      = ingHi_q;
    egrLo_d      = egrLo_q;
    egrHi_d      = egrHi_q;
    global_d     = global_q;
    queueLearn_d = queueLearn_q;
    if (wrEn)
    begin
      case (wordIdx)
        `IDX_INGRESS_LO:
          ingLo_d = lane_merge(ingLo_q, wrWord, wb_sel_i[1:0], `MASK_RATE_LO);
        `IDX_INGRESS_HI:
          ingHi_d = lane_merge(ingHi_q, wrWord, wb_sel_i[1:0], `MASK_RATE_HI);
        `IDX_EGRESS_LO:
          egrLo_d = lane_merge(egrLo_q, wrWord, wb_sel_i[1:0], `MASK_RATE_LO);
        `IDX_EGRESS_HI:
          egrHi_d = lane_merge(egrHi_q, wrWord, wb_sel_i[1:0], `MASK_RATE_HI);
        `IDX_GLOBAL:
          global_d = lane_merge(global_q, wrWord, wb_sel_i[1:0], `MASK_GLOBAL);
        `IDX_QUEUE_LEARN:
          queueLearn_d = lane_merge(queueLearn_q, wrWord, wb_sel_i[1:0],
                                    `MASK_QUEUE_LEARN);
        default:
          ingLo_d = ingLo_q;
      endcase
    end
    // Flush request clears on completion; a fresh write of 1 wins
    if (flushDynDone && global_q[`BIT_FLUSH_DYN])
      global_d[`BIT_FLUSH_DYN] = 1'b0;
    if (wrEn && wordIdx == `IDX_GLOBAL && wb_sel_i[1] && wrWord[`BIT_FLUSH_DYN])
      global_d[`BIT_FLUSH_DYN] = 1'b1;
    else if (wrEn && wordIdx == `IDX_GLOBAL && wb_sel_i[1])
      global_d[`BIT_FLUSH_DYN] = global_q[`BIT_FLUSH_DYN] && !flushDynDone;
  end

  // Read mux
  always @*
  begin
    rdData_d = 32'h0000_0000;
    case (wordIdx)
      `IDX_INGRESS_LO:
        rdData_d[15:0] = ingLo_q;
      `IDX_INGRESS_HI:
        rdData_d[15:0] = ingHi_q;
      `IDX_EGRESS_LO:
        rdData_d[15:0] = egrLo_q;
      `IDX_EGRESS_HI:
        rdData_d[15:0] = egrHi_q;
      `IDX_GLOBAL:
        rdData_d[15:0] = global_q;
      `IDX_QUEUE_LEARN:
        rdData_d[15:0] = queueLearn_q;
      `IDX_HOST_STATUS:
        rdData_d[15:0] = {8'h00, global_q[`BIT_FLUSH_DYN], egrQueue_q,
                          egressHold, ingressDrop};
      default:
        rdData_d = 32'h0000_0000;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      ingLo_q      <= `RST_RATE;
      ingHi_q      <= `RST_RATE;
      egrLo_q      <= `RST_RATE;
      egrHi_q      <= `RST_RATE;
      global_q     <= `RST_GLOBAL;
      queueLearn_q <= `RST_QUEUE_LEARN;
      ack_q        <= 1'b0;
      rdData_q     <= 32'h0000_0000;
    end
    else
    begin
      ingLo_q      <= ingLo_d;
      ingHi_q      <= ingHi_d;
      egrLo_q      <= egrLo_d;
      egrHi_q      <= egrHi_d;
      global_q     <= global_d;
      queueLearn_q <= queueLearn_d;
      ack_q        <= access;
      if (rdEn)
        rdData_q <= rdData_d;
    end
  end

  // Shared refill window
  assign windowTick = (window_q == (`WINDOW_CYCLES - 1));

  always @(posedge core_clk)
  begin
    if (rst)
      window_q <= 10'h000;
    else if (windowTick)
      window_q <= 10'h000;
    else
      window_q <= window_q + 10'h001;
  end

  // Rate codes per priority: ingress 0..3 only, egress codes are taken from egrLo_q directly
  assign rateCodes[6:0]   = ingLo_q[`RATE_LO_MSB:`RATE_LO_LSB];
  assign rateCodes[13:7]  = ingLo_q[`RATE_HI_MSB:`RATE_HI_LSB];
  assign rateCodes[20:14] = ingHi_q[`RATE_LO_MSB:`RATE_LO_LSB];
  assign rateCodes[27:21] = ingHi_q[`RATE_HI_MSB:`RATE_HI_LSB];

  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1)
    begin : g_ingress
      localparam [1:0] PRIO = p;
      assign ingConsume[p] = ingressByte && (ingressPrio == PRIO);
      // Over-limit frames are dropped by the ingress path
      rate_token_limiter u_limit (
        .core_clk   (core_clk),
        .rst        (rst),
        .limitEn    (1'b1),
        .rateCode   (rateCodes[7*p+6:7*p]),
        .windowTick (windowTick),
        .consume    (ingConsume[p]),
        .overLimit  (ingressDrop[p])
      );
    end
  endgenerate

  // Egress: one queue uses only priority 0, two queues only priority 0 and 1
  assign egrQueueNow = queue_of(global_q[`MAP_MSB:`MAP_LSB],
                                queueLearn_q[`BIT_TWO_QUEUE], egressPrio);
  assign egrLimitEn[0] = egrLo_q[`BIT_EGRESS_EN];
  assign egrLimitEn[1] = egrLo_q[`BIT_EGRESS_EN] && queueLearn_q[`BIT_TWO_QUEUE];
  assign egrConsume[0] = egressByte && !egrQueueNow;
  assign egrConsume[1] = egressByte && egrQueueNow;

  // Hold only stalls the queue, frames are never discarded
  rate_token_limiter u_egress0 (
    .core_clk   (core_clk),
    .rst        (rst),
    .limitEn    (egrLimitEn[0]),
    .rateCode   (egrLo_q[`RATE_LO_MSB:`RATE_LO_LSB]),
    .windowTick (windowTick),
    .consume    (egrConsume[0]),
    .overLimit  (egressHold[0])
  );

  rate_token_limiter u_egress1 (
    .core_clk   (core_clk),
    .rst        (rst),
    .limitEn    (egrLimitEn[1]),
    .rateCode   (egrLo_q[`RATE_HI_MSB:`RATE_HI_LSB]),
    .windowTick (windowTick),
    .consume    (egrConsume[1]),
    .overLimit  (egressHold[1])
  );

  always @(posedge core_clk)
  begin
    if (rst)
      egrQueue_q <= 1'b0;
    else if (egressByte)
      egrQueue_q <= egrQueueNow;
  end

  // Software disables learning before a dynamic flush; not enforced here
  assign wb_ack_o          = ack_q;
  assign wb_dat_o          = rdData_q;
  assign egressQueue       = egrQueue_q;
  assign rmiiSampleFalling = ingLo_q[`BIT_SAMPLE_EDGE];
  assign flushDynReq       = global_q[`BIT_FLUSH_DYN];
  assign flushStaticEn     = global_q[`BIT_FLUSH_STATIC];
  assign learnDisable      = queueLearn_q[2:0];
  assign twoQueueMode      = queueLearn_q[`BIT_TWO_QUEUE];

endmodule

// File: hw/rate_limit_regs.vh
// Summary of operation
// - Host ingress word 0 holds the priority 1 limit in bits 14-8 and the priority 0 limit in bits 6-0, frames over the limit are dropped, not held back.
// - Host ingress word 1 holds the priority 3 limit in bits 14-8 and the priority 2 limit in bits 6-0, applied to received frames of those priorities.
// - A limit field of zero, its reset value, means no limiting at either line rate.
// - Bit 7 of ingress word 0 picks the reduced-MII input sample edge, 0 rising and 1 falling.
// - Host egress word 0 holds the priority 1 limit in bits 14-8 and the priority 0 limit in bits 6-0, egress frames are throttled and never dropped.
// - Host egress word 1 holds the priority 3 limit in bits 14-8 and the priority 2 limit in bits 6-0.
// - Bit 7 of egress word 0 switches egress limiting on when set and off when clear, resetting to 0.
// - With one egress queue, the reset setup, only the priority 0 egress limit is used.
// - With two egress queues only the priority 1 and 0 egress limits are used.
// - The queue-mapping field in bits 15-14 resets to 10, codes 01 and 11 send priorities 1-3 to queue 1 and priority 0 to queue 0, codes 00 and 10 are reserved.
// - Writing 1 to bit 10 of the global word flushes all learned address entries and the bit then clears itself.
// - Bit 9 of the global word enables flushing of the static table for spanning tree use.
// - Each port's learning-disable bit stops address learning on that port when set and resets to 0.
`ifndef RATE_LIMIT_REGS_VH
`define RATE_LIMIT_REGS_VH

// Register indexes, byte address is index times four
`define IDX_INGRESS_LO   10'h0A4
`define IDX_INGRESS_HI   10'h0A6
`define IDX_EGRESS_LO    10'h0A8
`define IDX_EGRESS_HI    10'h0AA
`define IDX_GLOBAL       10'h0AC
`define IDX_QUEUE_LEARN  10'h0C0
`define IDX_HOST_STATUS  10'h0C2

// Field positions
`define RATE_HI_MSB      14
`define RATE_HI_LSB      8
`define RATE_LO_MSB      6
`define RATE_LO_LSB      0
`define BIT_SAMPLE_EDGE  7
`define BIT_EGRESS_EN    7
`define MAP_MSB          15
`define MAP_LSB          14
`define BIT_FLUSH_DYN    10
`define BIT_FLUSH_STATIC 9
`define BIT_TWO_QUEUE    4

// Writable masks and reset values
`define MASK_RATE_LO     16'h7FFF
`define MASK_RATE_HI     16'h7F7F
`define MASK_GLOBAL      16'hC7FF
`define MASK_QUEUE_LEARN 16'h0017
`define RST_RATE         16'h0000
`define RST_GLOBAL       16'h8000
`define RST_QUEUE_LEARN  16'h0000

// Queue mapping codes
`define MAP_SPLIT_A      2'h1
`define MAP_SPLIT_B      2'h3

// Rate window timing
`define CLK_PERIOD_NS    10
`define WINDOW_NS        8000
`define WINDOW_CYCLES    (`WINDOW_NS / `CLK_PERIOD_NS)
`define BYTES_PER_CODE   8'h01

`endif

// File: hw/rate_code_table.v
`timescale 1ns/10ps
`include "rate_limit_regs.vh"

module rate_code_table #(
  parameter [7:0] BYTES_PER_CODE = `BYTES_PER_CODE
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Code in, byte budget per window out
  input  wire [6:0]  rateCode,
  output reg  [15:0] creditBytes
);

  wire [14:0] product;

  assign product = rateCode * BYTES_PER_CODE;

  always @(posedge core_clk)
  begin
    if (rst)
      creditBytes <= 16'h0000;
    else
      creditBytes <= {1'b0, product};
  end

endmodule

// File: hw/rate_token_limiter.v
`timescale 1ns/10ps
`include "rate_limit_regs.vh"

module rate_token_limiter (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // Control
  input  wire       limitEn,
  input  wire [6:0] rateCode,
  input  wire       windowTick,
  // Traffic
  input  wire       consume,
  output reg        overLimit
);

  wire [15:0] creditBytes;
  reg  [15:0] used_q;
  reg  [15:0] used_d;

  rate_code_table u_table (
    .core_clk    (core_clk),
    .rst         (rst),
    .rateCode    (rateCode),
    .creditBytes (creditBytes)
  );

  always @*
  begin
    used_d = used_q;
    if (windowTick)
      used_d = {15'h0000, consume};
    else if (consume && used_q != 16'hFFFF)
      used_d = used_q + 16'h0001;
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      used_q    <= 16'h0000;
      overLimit <= 1'b0;
    end
    else
    begin
      used_q    <= used_d;
      overLimit <= limitEn && (rateCode != 7'h00) && (used_d >= creditBytes);
    end
  end

endmodule

// File: sim/port3_rate_limit_chk.sv
`timescale 1ns/10ps
module port3_rate_limit_chk (
  // Clock and reset
  input logic        core_clk,
  input logic        rst,
  // Register bus
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [11:0] wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic        wb_ack_o,
  // Egress and control signals
  input logic        egressByte,
  input logic        egressQueue,
  input logic        rmiiSampleFalling,
  input logic        flushDynDone,
  input logic        flushDynReq,
  input logic        flushStaticEn,
  input logic [2:0]  learnDisable,
  input logic        twoQueueMode
);
  wire tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = tk & wb_we_i;
  wire wG = wr & (wb_adr_i[11:2] == 10'h0AC) & wb_sel_i[1];
  wire wL = wr & (wb_adr_i[11:2] == 10'h0C0) & wb_sel_i[0];
  wire wI = wr & (wb_adr_i[11:2] == 10'h0A4) & wb_sel_i[0];

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_ACK: assert property (tk |=> wb_ack_o) else $error("no ack");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_EDGE: assert property (wI |=> rmiiSampleFalling == $past(wb_dat_i[7]))
    else $error("sample edge bit wrong");
  AST_FLUSH_SET: assert property (wG && wb_dat_i[10] |=> flushDynReq)
    else $error("flush not raised");
  AST_FLUSH_HOLD: assert property (flushDynReq && !flushDynDone |=> flushDynReq)
    else $error("flush dropped early");
  AST_FLUSH_CLR: assert property (flushDynReq && flushDynDone && !wG |=> !flushDynReq)
    else $error("flush not cleared");
  AST_STATIC: assert property (wG |=> flushStaticEn == $past(wb_dat_i[9]))
    else $error("static flush enable wrong");
  AST_LEARN: assert property (wL |=> learnDisable == $past(wb_dat_i[2:0]))
    else $error("learn disable wrong");
  AST_ONEQ: assert property (!twoQueueMode && egressByte |=> !egressQueue)
    else $error("single queue misrouted");
  AST_RST: assert property (disable iff (1'b0) rst |=> !wb_ack_o && !flushDynReq && learnDisable == 3'h0)
    else $error("reset state wrong");

  cover property (wG && wb_dat_i[10]);
  cover property (flushDynReq && flushDynDone);
  cover property (twoQueueMode && egressByte);
endmodule

bind port3_rate_limit_control port3_rate_limit_chk port3_rate_limit_chk_inst (
  .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .egressByte(egressByte), .egressQueue(egressQueue),
  .rmiiSampleFalling(rmiiSampleFalling), .flushDynDone(flushDynDone),
  .flushDynReq(flushDynReq), .flushStaticEn(flushStaticEn),
  .learnDisable(learnDisable), .twoQueueMode(twoQueueMode));

// File: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i, ingressDrop;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        ingressByte, egressByte, flushDynDone, egressQueue;
  logic [1:0]  ingressPrio, egressPrio, egressHold;
  logic        rmiiSampleFalling, flushDynReq, flushStaticEn, twoQueueMode;
  logic [2:0]  learnDisable;
  logic [15:0] rd;
  int          num_errors = 0;
  int          n_checks = 0;
  logic [11:0] adrT [0:5] = '{12'h290, 12'h298, 12'h2A0, 12'h2A8, 12'h2B0, 12'h300};
  logic [15:0] rstT [0:5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
  logic [15:0] mskT [0:3] = '{16'h7FFF, 16'h7F7F, 16'h7FFF, 16'h7F7F};

  port3_rate_limit_control port3_rate_limit_control_inst (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ingressByte(ingressByte),
    .ingressPrio(ingressPrio), .ingressDrop(ingressDrop), .egressByte(egressByte),
    .egressPrio(egressPrio), .egressHold(egressHold), .egressQueue(egressQueue),
    .rmiiSampleFalling(rmiiSampleFalling), .flushDynDone(flushDynDone),
    .flushDynReq(flushDynReq), .flushStaticEn(flushStaticEn),
    .learnDisable(learnDisable), .twoQueueMode(twoQueueMode));

  initial
  begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle, held until ack is sampled
  task xfer(input logic [11:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1)
    begin
      @(posedge core_clk);
      n++;
    end
    rd = wb_dat_o[15:0];
    chk(n, 1);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge core_clk);
  endtask

  task rchk(input logic [11:0] a, input logic [15:0] e);
    xfer(a, 0, 16'h0000);
    chk(rd, e);
  endtask

  task bytes(input logic eg, input logic [1:0] p, input int k);
    egressByte <= eg;
    ingressByte <= !eg;
    egressPrio <= p;
    ingressPrio <= p;
    repeat (k) @(posedge core_clk);
    egressByte <= 0;
    ingressByte <= 0;
    repeat (2) @(posedge core_clk);
  endtask

  // Start of a fresh rate window, seen as the fall of a saturated flag
  task sync_win(input logic [15:0] v);
    int n;
    n = 0;
    xfer(12'h290, 1, v);
    bytes(0, 0, 1);
    chk(ingressDrop[0], 1);
    while (ingressDrop[0] && n < 900)
    begin
      @(posedge core_clk);
      n++;
    end
    chk(ingressDrop[0], 0);
  endtask

  task t_regs;
    for (int i = 0; i < 6; i++)
      rchk(adrT[i], rstT[i]);
    xfer(12'h3FC, 1, 16'hFFFF);
    rchk(12'h3FC, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      xfer(adrT[i], 1, 16'hFFFF);
      rchk(adrT[i], mskT[i]);
      xfer(adrT[i], 1, 16'h0000);
    end
    $display("registers done");
  endtask

  task t_ing;
    logic [3:0] e;
    e = 4'h0;
    xfer(12'h298, 1, 16'h0504);
    sync_win(16'h0381);
    chk(rmiiSampleFalling, 1);
    for (int p = 1; p < 4; p++)
    begin
      bytes(0, p[1:0], p + 1);
      chk(ingressDrop, e);
      bytes(0, p[1:0], 1);
      e[p] = 1;
      chk(ingressDrop, e);
    end
    xfer(12'h298, 1, 16'h0000);
    sync_win(16'h0001);
    chk(rmiiSampleFalling, 0);
    for (int p = 1; p < 4; p++)
      bytes(0, p[1:0], 8);
    chk(ingressDrop[3:1], 3'h0);
    $display("ingress done");
  endtask

  task t_egr;
    xfer(12'h2A0, 1, 16'h0502);
    sync_win(16'h0001);
    bytes(1, 3, 4);
    chk(egressHold, 2'h0);
    chk(egressQueue, 0);
    xfer(12'h2A0, 1, 16'h0582);
    sync_win(16'h0001);
    bytes(1, 3, 1);
    chk(egressHold, 2'h0);
    bytes(1, 2, 1);
    chk(egressHold, 2'h1);
    xfer(12'h300, 1, 16'h0010);
    chk(twoQueueMode, 1);
    xfer(12'h2A8, 1, 16'h0101);
    xfer(12'h2B0, 1, 16'h4000);
    sync_win(16'h0001);
    bytes(1, 2, 4);
    chk({egressHold, egressQueue}, 3'h1);
    bytes(1, 0, 2);
    chk({egressHold, egressQueue}, 3'h2);
    bytes(1, 3, 1);
    chk(egressHold, 2'h3);
    for (int c = 0; c < 4; c++)
    begin
      xfer(12'h2B0, 1, {c[1:0], 14'h0000});
      bytes(1, 1, 1);
      chk(egressQueue, c[0]);
    end
    xfer(12'h300, 1, 16'h0000);
    $display("egress done");
  endtask

  task t_flush;
    xfer(12'h300, 1, 16'h0007);
    chk(learnDisable, 3'h7);
    xfer(12'h2B0, 1, 16'h8400);
    chk(flushDynReq, 1);
    rchk(12'h2B0, 16'h8400);
    flushDynDone <= 1;
    @(posedge core_clk);
    flushDynDone <= 0;
    repeat (2) @(posedge core_clk);
    chk(flushDynReq, 0);
    rchk(12'h2B0, 16'h8000);
    xfer(12'h2B0, 1, 16'h8200);
    chk(flushStaticEn, 1);
    xfer(12'h2B0, 1, 16'h8000);
    chk(flushStaticEn, 0);
    xfer(12'h300, 1, 16'h0000);
    chk(learnDisable, 3'h0);
    $display("flush done");
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, ingressByte, egressByte, flushDynDone} = 7'h40;
    rst = 1;
    {wb_adr_i, wb_sel_i, wb_dat_i, ingressPrio, egressPrio} = '0;
    repeat (5) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    t_regs;
    t_ing;
    t_egr;
    t_flush;
    close_out;
  end

  initial
  begin
    repeat (30000) @(posedge core_clk);
    num_errors++;
    close_out;
  end
endmodule
